// File: keyscan_host_command_core_bench.sv
// Purpose: Self-checking bench of the key-scan host command core.
// Assumes: MS_CYCLES of 10 keeps timed phases short.
// Notes: Table rows first, then queue, interrupt, aux and halt cases.
`timescale 1ns/100ps
module keyscan_host_command_core_bench;
    typedef struct packed {logic [7:0] code; logic [7:0] data;
        logic chk; logic [7:0] exp;} khc_row_t;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic key_evt_valid = 1'b0;
    logic [7:0] key_evt_code = 8'h00;
    logic key_down = 1'b1;
    logic key_overrun = 1'b0;
    logic [3:0] ext = 4'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, pwm_o, osc_run, irq_n, irq;
    logic [9:0] debounce_ms;
    logic [3:0] gpio_i, gpio_o, gpio_oe;
    int n_fail = 0;
    int total_checks = 0;
    khc_row_t rows [12] = '{'{8'he0, 8'h00, 1'b1, 8'h00}, '{8'hf8, 8'h0f, 1'b0, 8'h00},
        '{8'hf9, 8'h05, 1'b0, 8'h00}, '{8'hfa, 8'h00, 1'b1, 8'h05}, '{8'h22, 8'h03, 1'b0, 8'h00},
        '{8'he0, 8'h00, 1'b1, 8'h06}, '{8'h55, 8'h00, 1'b0, 8'h00}, '{8'he0, 8'h00, 1'b1, 8'h15},
        '{8'hf0, 8'h00, 1'b1, 8'h02}, '{8'hf0, 8'h00, 1'b1, 8'h00}, '{8'hd0, 8'h00, 1'b1, 8'h08},
        '{8'hd0, 8'h00, 1'b1, 8'h00}};
    khc_core #(.MS_CYCLES(10)) u_dut (.clk_sys(clk_sys), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .key_evt_valid(key_evt_valid),
        .key_evt_code(key_evt_code), .key_down(key_down), .key_overrun(key_overrun),
        .debounce_ms(debounce_ms), .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe(gpio_oe),
        .pwm_o(pwm_o), .osc_run(osc_run), .irq_n(irq_n), .irq(irq));
    khc_pin_model u_pins (.gpio_o(gpio_o), .gpio_oe(gpio_oe), .ext_lvl(ext), .gpio_i(gpio_i));
    // 40 MHz system clock
    always #12.5 clk_sys = ~clk_sys;
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task tally_and_finish;
        if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    // One bus transfer; data and error are taken at the ready edge only
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task cmd(input logic [7:0] c, input logic [15:0] d);
        apb(1'b1, khc_pkg::A_CMD, {8'h00, d, c});
    endtask : cmd
    task res(input logic [7:0] e, input string nm);
        apb(1'b0, khc_pkg::A_RESULT, 32'h0);
        chk(rd, {24'h0, e}, nm);
    endtask : res
    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        chk({22'h0, debounce_ms}, 32'h0000000a, "debounce");
        foreach (rows[i]) begin
            cmd(rows[i].code, {8'h00, rows[i].data});
            if (rows[i].chk) res(rows[i].exp, "result");
        end
        chk({31'h0, irq_n}, 32'h1, "irq_n");
        // Fifteen events into a fourteen-entry queue
        for (int i = 1; i <= 15; i++) begin
            @(posedge clk_sys);
            key_evt_code <= 8'(i);
            key_evt_valid <= 1'b1;
            key_overrun <= (i == 15);
        end
        @(posedge clk_sys);
        key_evt_valid <= 1'b0;
        key_overrun <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq_n}, 32'h0, "irq_n");
        apb(1'b0, khc_pkg::A_STATE, 32'h0);
        chk({28'h0, rd[7:4]}, 32'h0000000e, "count");
        for (int i = 1; i <= 15; i++) begin
            apb(1'b0, khc_pkg::A_EVDATA, 32'h0);
            chk(rd, (i == 15) ? 32'h0 : 32'(i), "event");
        end
        cmd(8'h21, 16'h0);
        apb(1'b0, khc_pkg::A_EVDATA, 32'h0);
        chk(rd, 32'h1, "repeat");
        cmd(8'h20, 16'h0);
        apb(1'b0, khc_pkg::A_STATE, 32'h0);
        chk({28'h0, rd[7:4]}, 32'h0000000d, "count");
        cmd(8'hd0, 16'h0);
        res(8'h09, "intcode");
        chk({31'h0, irq_n}, 32'h1, "irq_n");
        cmd(8'hf0, 16'h0);
        res(8'h44, "error");
        // Mask, raise and clear the done interrupt; then an unmapped read
        apb(1'b1, khc_pkg::A_IMR, 32'h8);
        #1 chk({31'h0, irq}, 32'h1, "irq");
        apb(1'b1, khc_pkg::A_ISR, 32'hf);
        #1 chk({31'h0, irq}, 32'h0, "irq");
        apb(1'b1, khc_pkg::A_IMR, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, er}, 32'h1, "slverr");
        chk(rd, 32'h0, "unmapped");
        // Lone aux source sets both edge bits
        cmd(8'hf8, 16'h0);
        cmd(8'hd1, 16'h1);
        @(posedge clk_sys);
        ext <= 4'h1;
        repeat (4) @(posedge clk_sys);
        cmd(8'hd0, 16'h0);
        res(8'h06, "intcode");
        // Static level, then the timer with zero duty takes the pin
        cmd(8'h32, 16'h2);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, pwm_o}, 32'h1, "pwm_o");
        cmd(8'h30, 16'h3);
        cmd(8'h31, 16'h0);
        cmd(8'h32, 16'h3);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, pwm_o}, 32'h0, "pwm_o");
        // Halt after active time, refused first access, then edge wake
        cmd(8'h24, 16'hd);
        @(posedge clk_sys);
        key_down <= 1'b0;
        repeat (160) @(posedge clk_sys);
        chk({31'h0, osc_run}, 32'h0, "osc_run");
        cmd(8'he0, 16'h0);
        chk({31'h0, er}, 32'h1, "slverr");
        key_down <= 1'b1;
        repeat (3) @(posedge clk_sys);
        cmd(8'hf0, 16'h0);
        res(8'h01, "error");
        key_down <= 1'b0;
        repeat (160) @(posedge clk_sys);
        ext <= 4'h0;
        repeat (3) @(posedge clk_sys);
        key_down <= 1'b1;
        cmd(8'he0, 16'h0);
        res(8'h02, "status");
        tally_and_finish();
    end
endmodule : keyscan_host_command_core_bench
bind khc_core khc_core_sva #(.MS_CYCLES(MS_CYCLES)) u_sva (.clk_sys(clk_sys), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pslverr(pslverr), .key_evt_valid(key_evt_valid), .key_down(key_down),
    .debounce_ms(debounce_ms), .gpio_o(gpio_o), .gpio_oe(gpio_oe), .osc_run(osc_run),
    .irq_n(irq_n));

// File: khc_core.sv
// Purpose: Host command core: event queue, interrupt codes, power and pins.
// Assumes: All inputs synchronous to clk_sys; scanner feeds key events.
// Notes: Commands are written to A_CMD; read answers land in A_RESULT, queued events in A_EVDATA.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
module khc_core #(
    parameter int MS_CYCLES = khc_pkg::MS_CYCLES_DEF
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Key scanner
    input wire logic key_evt_valid,
    input wire logic [7:0] key_evt_code,
    input wire logic key_down,
    input wire logic key_overrun,
    output logic [9:0] debounce_ms,
    // Pins
    input wire logic [3:0] gpio_i,
    output logic [3:0] gpio_o,
    output logic [3:0] gpio_oe,
    output logic pwm_o,
    // Power and interrupts
    output logic osc_run,
    output logic irq_n,
    output logic irq
);
    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);
    localparam logic [3:0] DEPTH4 = 4'(khc_pkg::FIFO_DEPTH);

    khc_pkg::khc_pwr_t pwr_r;
    khc_pkg::khc_cmd_t cmd;
    logic acc, refused, mapped, wr_acc, rd_acc, cmd_go, cmd_known;
    logic [3:0] cursor_r, drop_cnt, fifo_count;
    logic [7:0] peek_data;
    logic [7:0] result_r, status_r, err_r, err_set;
    logic [khc_pkg::IC_W-1:0] int_code_r, int_set;
    logic [khc_pkg::IS_W-1:0] isr_r, imr_r, isr_set;
    logic [1:0] ext_en_r, aux_prev_r, edges, ext_set;
    logic [9:0] debounce_r;
    logic [15:0] active_ms_r, idle_ms_r, ms_cnt_r;
    logic ms_tick, wake_req;
    logic [3:0] gpio_dir_r, gpio_out_r;
    logic [15:0] pwm_period_r, pwm_duty_r;
    logic [1:0] pwm_ctl_r;
    logic pwm_wave, pwm_r;

    // APB decode; zero wait states, unmapped or refused gives pslverr
    assign acc = psel && penable;
    assign refused = pwr_r != khc_pkg::PW_ACTIVE;
    always_comb begin
        unique case (paddr)
            khc_pkg::A_CMD, khc_pkg::A_RESULT, khc_pkg::A_EVDATA,
            khc_pkg::A_ISR, khc_pkg::A_IMR, khc_pkg::A_STATE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pready = 1'b1;
    assign pslverr = acc && (!mapped || refused);
    assign wr_acc = acc && pwrite && mapped && !refused;
    assign rd_acc = acc && !pwrite && mapped && !refused;

    // Read mux over stored state and live gpio_i; A_CMD reads back the low 24 bits of the current pwdata
    always_comb begin
        prdata = '0;
        if (rd_acc) begin
            unique case (paddr)
                khc_pkg::A_CMD: prdata = 32'(cmd);
                khc_pkg::A_RESULT: prdata = 32'(result_r);
                khc_pkg::A_EVDATA: prdata = 32'(peek_data);
                khc_pkg::A_ISR: prdata = 32'(isr_r);
                khc_pkg::A_IMR: prdata = 32'(imr_r);
                khc_pkg::A_STATE: prdata = 32'({pwr_r, fifo_count, gpio_i});
                default: prdata = '0;
            endcase
        end
    end

    // Command decode
    assign cmd = khc_pkg::khc_cmd_t'(pwdata[khc_pkg::CMD_W-1:0]);
    assign cmd_go = wr_acc && (paddr == khc_pkg::A_CMD);
    always_comb begin
        case (cmd.code)
            khc_pkg::CMD_EVENT_READ, khc_pkg::CMD_REPEAT_READ, khc_pkg::CMD_DEBOUNCE,
            khc_pkg::CMD_ACTIVE_TIME, khc_pkg::CMD_PWM_PERIOD, khc_pkg::CMD_PWM_DUTY,
            khc_pkg::CMD_PWM_CTRL, khc_pkg::CMD_READ_INT, khc_pkg::CMD_SET_EXT_INT,
            khc_pkg::CMD_READ_STAT, khc_pkg::CMD_READ_ERROR, khc_pkg::CMD_GPIO_DIR,
            khc_pkg::CMD_GPIO_OUT, khc_pkg::CMD_GPIO_READ: cmd_known = 1'b1;
            default: cmd_known = 1'b0;
        endcase
    end

    // Event queue; a new read commits what the last read delivered
    assign drop_cnt = (cmd_go && cmd.code == khc_pkg::CMD_EVENT_READ) ? cursor_r : '0;
    khc_event_fifo u_fifo (
        .clk_sys(clk_sys),
        .srst(srst),
        .push(key_evt_valid),
        .push_data(key_evt_code),
        .drop_cnt(drop_cnt),
        .peek_idx(cursor_r),
        .peek_data(peek_data),
        .count(fifo_count)
    );

    // Read cursor: repeat read rewinds it without consuming entries
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cursor_r <= '0;
        end else if (cmd_go && (cmd.code == khc_pkg::CMD_EVENT_READ ||
                                cmd.code == khc_pkg::CMD_REPEAT_READ)) begin
            cursor_r <= '0;
        end else if (rd_acc && paddr == khc_pkg::A_EVDATA && cursor_r < fifo_count) begin
            cursor_r <= cursor_r + 4'h1;
        end
    end

    // Aux pin edges; a lone enabled source sets both edge bits
    assign edges = (gpio_i[khc_pkg::AUX_B:khc_pkg::AUX_A] ^ aux_prev_r) & ext_en_r
                   & ~gpio_dir_r[khc_pkg::AUX_B:khc_pkg::AUX_A];
    assign ext_set[0] = edges[0] | (edges[1] & ~ext_en_r[0]);
    assign ext_set[1] = edges[1] | (edges[0] & ~ext_en_r[1]);
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            aux_prev_r <= '0;
        end else begin
            aux_prev_r <= gpio_i[khc_pkg::AUX_B:khc_pkg::AUX_A];
        end
    end

    // New error causes
    always_comb begin
        err_set = '0;
        err_set[khc_pkg::ER_FIFO] = key_evt_valid && fifo_count == DEPTH4
                                    && drop_cnt == '0;
        err_set[khc_pkg::ER_KEYS] = key_overrun;
        err_set[khc_pkg::ER_UNK] = cmd_go && !cmd_known;
        err_set[khc_pkg::ER_EARLY] = acc && refused;
        err_set[khc_pkg::ER_WDRAW] = cmd_go && cmd.code == khc_pkg::CMD_SET_EXT_INT
            && |(ext_en_r & ~cmd.data[1:0])
            && (int_code_r[khc_pkg::IC_EXA] | int_code_r[khc_pkg::IC_EXB]);
    end

    // Error byte: read command clears it, a same-cycle new error survives
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            err_r <= '0;
        end else if (cmd_go && cmd.code == khc_pkg::CMD_READ_ERROR) begin
            err_r <= err_set;
        end else begin
            err_r <= err_r | err_set;
        end
    end

    // Interrupt code: set wins over the acknowledge in the same cycle
    always_comb begin
        int_set = '0;
        int_set[khc_pkg::IC_KEY] = key_evt_valid;
        int_set[khc_pkg::IC_EXA] = ext_set[0];
        int_set[khc_pkg::IC_EXB] = ext_set[1];
        int_set[khc_pkg::IC_ERR] = |err_set;
    end
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            int_code_r <= '0;
        end else if (cmd_go && cmd.code == khc_pkg::CMD_READ_INT) begin
            int_code_r <= int_set;
        end else begin
            int_code_r <= int_code_r | int_set;
        end
    end
    assign irq_n = ~|int_code_r;

    // Answer byte for read commands
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            result_r <= '0;
        end else if (cmd_go) begin
            case (cmd.code)
                khc_pkg::CMD_READ_INT: result_r <= 8'(int_code_r);
                khc_pkg::CMD_READ_STAT: result_r <= status_r;
                khc_pkg::CMD_READ_ERROR: result_r <= err_r;
                khc_pkg::CMD_GPIO_READ: result_r <= 8'(gpio_i);
                default: result_r <= result_r;
            endcase
        end
    end

    // Status: reading it leaves it unchanged so it tells of the prior command
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            status_r <= khc_pkg::ST_RESET;
        end else if (cmd_go && cmd.code != khc_pkg::CMD_READ_STAT) begin
            status_r <= cmd_known ? khc_pkg::ST_ACK : khc_pkg::ST_NOACK;
        end else if (pwr_r == khc_pkg::PW_HALT && |edges) begin
            status_r <= khc_pkg::ST_WAKE_EXT;
        end
    end

    // Host settings
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            debounce_r <= khc_pkg::DEB_RESET_MS;
            active_ms_r <= khc_pkg::ACT_RESET_MS;
            ext_en_r <= '0;
            gpio_dir_r <= '0;
            gpio_out_r <= '0;
            pwm_period_r <= '0;
            pwm_duty_r <= '0;
            pwm_ctl_r <= '0;
        end else if (cmd_go) begin
            case (cmd.code)
                khc_pkg::CMD_DEBOUNCE:
                    debounce_r <= 10'(cmd.data[7:0]) * khc_pkg::DEB_STEP_MS;
                khc_pkg::CMD_ACTIVE_TIME: active_ms_r <= cmd.data;
                khc_pkg::CMD_SET_EXT_INT: ext_en_r <= cmd.data[1:0];
                khc_pkg::CMD_GPIO_DIR: gpio_dir_r <= cmd.data[3:0];
                khc_pkg::CMD_GPIO_OUT: gpio_out_r <= cmd.data[3:0];
                khc_pkg::CMD_PWM_PERIOD: pwm_period_r <= cmd.data;
                khc_pkg::CMD_PWM_DUTY: pwm_duty_r <= cmd.data;
                khc_pkg::CMD_PWM_CTRL: pwm_ctl_r <= cmd.data[1:0];
                default: ext_en_r <= ext_en_r;
            endcase
        end
    end
    assign debounce_ms = debounce_r;
    assign gpio_o = gpio_out_r;
    assign gpio_oe = gpio_dir_r;

    // Modulated pin, or static level when the timer is off
    khc_pwm_timer u_pwm (
        .clk_sys(clk_sys),
        .srst(srst),
        .enable(pwm_ctl_r[khc_pkg::PWM_EN_BIT]),
        .period(pwm_period_r),
        .duty(pwm_duty_r),
        .wave(pwm_wave)
    );
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pwm_r <= 1'b0;
        end else begin
            pwm_r <= pwm_ctl_r[khc_pkg::PWM_EN_BIT] ? pwm_wave
                     : pwm_ctl_r[khc_pkg::PWM_LVL_BIT];
        end
    end
    assign pwm_o = pwm_r;

    // Millisecond tick and idle time since the last key activity
    assign ms_tick = ms_cnt_r == MS_LAST;
    always_ff @(posedge clk_sys) begin
        if (srst || pwr_r != khc_pkg::PW_ACTIVE) begin
            ms_cnt_r <= '0;
        end else begin
            ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 16'h0001;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (srst || key_down || key_evt_valid || pwr_r != khc_pkg::PW_ACTIVE) begin
            idle_ms_r <= '0;
        end else if (ms_tick && idle_ms_r != '1) begin
            idle_ms_r <= idle_ms_r + 16'h0001;
        end
    end

    // Power state; halt stops the oscillator until a wake source appears
    assign wake_req = psel || key_down || key_evt_valid || |edges;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pwr_r <= khc_pkg::PW_ACTIVE;
        end else begin
            unique case (pwr_r)
                khc_pkg::PW_ACTIVE: begin
                    if (!key_down && idle_ms_r >= active_ms_r) begin
                        pwr_r <= khc_pkg::PW_HALT;
                    end
                end
                khc_pkg::PW_HALT: begin
                    if (wake_req) begin
                        pwr_r <= khc_pkg::PW_WAKE;
                    end
                end
                khc_pkg::PW_WAKE: pwr_r <= khc_pkg::PW_ACTIVE;
                default: pwr_r <= khc_pkg::PW_ACTIVE;
            endcase
        end
    end
    assign osc_run = pwr_r != khc_pkg::PW_HALT;

    // Sticky interrupt status, write one to clear, set wins
    always_comb begin
        isr_set = '0;
        isr_set[khc_pkg::IS_KEY] = key_evt_valid;
        isr_set[khc_pkg::IS_EDGE] = |edges;
        isr_set[khc_pkg::IS_ERR] = |err_set;
        isr_set[khc_pkg::IS_DONE] = cmd_go;
    end
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            isr_r <= '0;
        end else if (wr_acc && paddr == khc_pkg::A_ISR) begin
            isr_r <= (isr_r & ~pwdata[khc_pkg::IS_W-1:0]) | isr_set;
        end else begin
            isr_r <= isr_r | isr_set;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            imr_r <= '0;
        end else if (wr_acc && paddr == khc_pkg::A_IMR) begin
            imr_r <= pwdata[khc_pkg::IS_W-1:0];
        end
    end
    assign irq = |(isr_r & imr_r);
endmodule : khc_core

// File: khc_core_sva.sv
// Purpose: Port-level checks of the key-scan host command core.
// Assumes: Bound to khc_core; one clock domain.
// Notes: Latency windows follow the registered outputs of the core.
`timescale 1ns/100ps
module khc_core_sva #(
    parameter int MS_CYCLES = 10
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    // Scanner, pins, power
    input wire logic key_evt_valid,
    input wire logic key_down,
    input wire logic [9:0] debounce_ms,
    input wire logic [3:0] gpio_o,
    input wire logic [3:0] gpio_oe,
    input wire logic osc_run,
    input wire logic irq_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // Accepted command write, refused ones excluded
    wire logic wr = psel && penable && pwrite && paddr == khc_pkg::A_CMD && !pslverr;
    property p_rst;
        disable iff (1'b0) srst |=> debounce_ms == khc_pkg::DEB_RESET_MS && irq_n && osc_run;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
    property p_ack;
        $rose(irq_n) |-> $past(wr && pwdata[7:0] == khc_pkg::CMD_READ_INT);
    endproperty
    a_ack: assert property (p_ack) else $error("irq released without ack");
    property p_key;
        key_evt_valid |-> ##[1:2] !irq_n;
    endproperty
    a_key: assert property (p_key) else $error("key event gave no irq");
    property p_wake;
        key_down |-> ##[1:3] osc_run;
    endproperty
    a_wake: assert property (p_wake) else $error("keys did not wake");
    property p_ref;
        psel && !penable && !osc_run |=> pslverr;
    endproperty
    a_ref: assert property (p_ref) else $error("halted access accepted");
    property p_deb;
        wr && pwdata[7:0] == khc_pkg::CMD_DEBOUNCE
            |=> debounce_ms == {$past(pwdata[15:8]), 2'b00};
    endproperty
    a_deb: assert property (p_deb) else $error("debounce not set");
    property p_out;
        wr && pwdata[7:0] == khc_pkg::CMD_GPIO_OUT |=> gpio_o == $past(pwdata[11:8]);
    endproperty
    a_out: assert property (p_out) else $error("pin level not set");
    property p_dir;
        wr && pwdata[7:0] == khc_pkg::CMD_GPIO_DIR |=> gpio_oe == $past(pwdata[11:8]);
    endproperty
    a_dir: assert property (p_dir) else $error("pin direction not set");
    c_key: cover property (key_evt_valid);
    c_halt: cover property ($fell(osc_run));
    c_ack: cover property ($rose(irq_n));
endmodule : khc_core_sva

// File: khc_event_fifo.sv
// Purpose: Fourteen-entry key event queue with peek and bulk drop.
// Assumes: drop_cnt never exceeds the current count.
// Notes: Pushes into a full queue are discarded; the caller flags them.
`timescale 1ns/100ps
module khc_event_fifo (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Fill side
    input wire logic push,
    input wire logic [7:0] push_data,
    // Drain side
    input wire logic [3:0] drop_cnt,
    input wire logic [3:0] peek_idx,
    output logic [7:0] peek_data,
    output logic [3:0] count
);
    localparam logic [4:0] DEPTH5 = 5'(khc_pkg::FIFO_DEPTH);
    localparam logic [3:0] DEPTH4 = 4'(khc_pkg::FIFO_DEPTH);

    logic [7:0] mem_r [khc_pkg::FIFO_DEPTH];
    logic [3:0] head_r;
    logic [3:0] tail_r;
    logic [3:0] count_r;
    logic do_push;

    function automatic logic [3:0] wrap(input logic [4:0] v);
        return (v >= DEPTH5) ? 4'(v - DEPTH5) : v[3:0];
    endfunction

    // Room freed by a drop in the same cycle counts, so no event is lost unflagged
    assign do_push = push && (count_r - drop_cnt != DEPTH4);

    // Pointers and fill level
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            head_r <= '0;
            tail_r <= '0;
            count_r <= '0;
        end else begin
            head_r <= wrap({1'b0, head_r} + {1'b0, drop_cnt});
            if (do_push) begin
                tail_r <= wrap({1'b0, tail_r} + 5'h01);
            end
            count_r <= count_r - drop_cnt + 4'(do_push);
        end
    end

    // Storage; entries carry no reset since count guards them
    always_ff @(posedge clk_sys) begin
        if (do_push) begin
            mem_r[tail_r] <= push_data;
        end
    end

    // Past the last entry the empty code reads back
    assign peek_data = (peek_idx < count_r) ?
        mem_r[wrap({1'b0, head_r} + {1'b0, peek_idx})] : khc_pkg::EMPTY_CODE;
    assign count = count_r;
endmodule : khc_event_fifo

// File: khc_pin_model.sv
// Purpose: Board-side model of the four general pins.
// Assumes: Outside level comes from the bench.
// Notes: A driven pin reads back what the core drives.
`timescale 1ns/100ps
module khc_pin_model (
    // Core side
    input wire logic [3:0] gpio_o,
    input wire logic [3:0] gpio_oe,
    // Board side
    input wire logic [3:0] ext_lvl,
    output logic [3:0] gpio_i
);
    // Wire level resolved from the enables
    assign gpio_i = (gpio_oe & gpio_o) | (~gpio_oe & ext_lvl);
endmodule : khc_pin_model

// File: khc_pkg.sv
// Purpose: Shared constants and types of the key-scan host command core.
// Assumes: 40 MHz clk_sys, APB register access, synchronous inputs.
// Notes: Command codes without a printed value are local choices.
package khc_pkg;
    // Event queue
    localparam int FIFO_DEPTH = 14;
    localparam logic [7:0] EMPTY_CODE = 8'h00;

    // Command codes
    localparam logic [7:0] CMD_EVENT_READ = 8'h20;
    localparam logic [7:0] CMD_REPEAT_READ = 8'h21;
    localparam logic [7:0] CMD_DEBOUNCE = 8'h22;
    localparam logic [7:0] CMD_ACTIVE_TIME = 8'h24;
    localparam logic [7:0] CMD_PWM_PERIOD = 8'h30;
    localparam logic [7:0] CMD_PWM_DUTY = 8'h31;
    localparam logic [7:0] CMD_PWM_CTRL = 8'h32;
    localparam logic [7:0] CMD_READ_INT = 8'hd0;
    localparam logic [7:0] CMD_SET_EXT_INT = 8'hd1;
    localparam logic [7:0] CMD_READ_STAT = 8'he0;
    localparam logic [7:0] CMD_READ_ERROR = 8'hf0;
    localparam logic [7:0] CMD_GPIO_DIR = 8'hf8;
    localparam logic [7:0] CMD_GPIO_OUT = 8'hf9;
    localparam logic [7:0] CMD_GPIO_READ = 8'hfa;

    // Status codes
    localparam logic [7:0] ST_RESET = 8'h00;
    localparam logic [7:0] ST_WAKE_EXT = 8'h02;
    localparam logic [7:0] ST_ACK = 8'h06;
    localparam logic [7:0] ST_NOACK = 8'h15;

    // Interrupt code bits
    localparam int IC_W = 4;
    localparam int IC_KEY = 0;
    localparam int IC_EXA = 1;
    localparam int IC_EXB = 2;
    localparam int IC_ERR = 3;

    // Error code bits
    localparam int ER_EARLY = 0;
    localparam int ER_UNK = 1;
    localparam int ER_KEYS = 2;
    localparam int ER_WDRAW = 4;
    localparam int ER_FIFO = 6;

    // Pins
    localparam int GPIO_N = 4;
    localparam int AUX_A = 0;
    localparam int AUX_B = 1;
    localparam int PWM_EN_BIT = 0;
    localparam int PWM_LVL_BIT = 1;

    // APB map
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_RESULT = 8'h04;
    localparam logic [7:0] A_EVDATA = 8'h08;
    localparam logic [7:0] A_ISR = 8'h0c;
    localparam logic [7:0] A_IMR = 8'h10;
    localparam logic [7:0] A_STATE = 8'h14;

    // Sticky status bits
    localparam int IS_W = 4;
    localparam int IS_KEY = 0;
    localparam int IS_EDGE = 1;
    localparam int IS_ERR = 2;
    localparam int IS_DONE = 3;

    // Timing
    localparam logic [9:0] DEB_RESET_MS = 10'h00a;
    localparam logic [9:0] DEB_STEP_MS = 10'h004;
    localparam logic [15:0] ACT_RESET_MS = 16'h01f4;
    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;

    // Power states
    typedef enum logic [2:0] {
        PW_ACTIVE = 3'b001,
        PW_HALT = 3'b010,
        PW_WAKE = 3'b100
    } khc_pwr_t;

    // Command word as written to A_CMD
    typedef struct packed {
        logic [15:0] data;
        logic [7:0] code;
    } khc_cmd_t;
    localparam int CMD_W = $bits(khc_cmd_t);
endpackage : khc_pkg

// File: khc_pwm_timer.sv
// Purpose: 16-bit period and duty timer for the modulated pin.
// Assumes: Period and duty are held stable by the caller.
// Notes: Output is high while the count is below duty.
`timescale 1ns/100ps
module khc_pwm_timer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Settings
    input wire logic enable,
    input wire logic [15:0] period,
    input wire logic [15:0] duty,
    // Waveform
    output logic wave
);
    logic [15:0] cnt_r;
    logic wave_r;

    // Free counter, restarted when disabled so each run starts aligned
    always_ff @(posedge clk_sys) begin
        if (srst || !enable) begin
            cnt_r <= '0;
            wave_r <= 1'b0;
        end else begin
            cnt_r <= (cnt_r >= period) ? '0 : cnt_r + 16'h0001;
            wave_r <= cnt_r < duty;
        end
    end

    assign wave = wave_r;
endmodule : khc_pwm_timer
